// File: rtl/ccs_top.sv
// CPU clock source selector with oscillator stop control and Avalon registers.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Stabilization time select applies only on stop exit from high-speed.
// - Internal oscillator stop works only when option permits software stop.
// - Subsystem status is 1 only on subsystem; main status 0 only internal.
// - Subsystem mode needs only subsystem select 1; processor stop 0 keeps oscillator.
// - On subsystem clock, processor-control stop flag stops high-speed oscillator.
// - On subsystem clock, internal stop flag stops internal oscillator if permitted.
// - On high-speed clock, both high-speed stop flags are ignored.
// - On internal clock, only main stop flag stops high-speed oscillator.
// - On subsystem clock, main stop flag does not stop high-speed oscillator.
// - Main select bit 0 chooses source; bit 1 reports active one.
// - Internal to high-speed changeover completes within three clocks.
module ccs_top
(
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Avalon-MM slave.
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // Configuration and system events.
   input  wire logic        int_osc_sw_stoppable,
   input  wire logic        stop_exit_by_irq,
   input  wire logic        hs_osc_stab_done,
   // Oscillator controls and clock tree.
   output logic             hs_osc_run,
   output logic             int_osc_run,
   output logic [1:0]       cpu_clk_src,
   output logic             cpu_clk_gate,
   output logic [2:0]       stab_time_apply
);

   logic                rst_sync1_r;
   logic                rst_sync2_r;
   logic                main_source_select;
   logic                sub_clock_select;
   logic                hs_osc_stop_by_proc_ctrl;
   logic                main_osc_stop_flag;
   logic                int_osc_stop_flag;
   logic [2:0]          osc_stab_time_select;
   logic [15:0]         osc_stab_status_counter;
   logic                wait_r;
   ccs_pkg::ccs_src_e   req_src;
   ccs_pkg::ccs_src_e   act_src;
   logic                gate_open;
   logic                sw_busy;
   logic                sub_clock_status;
   logic                main_source_status;
   logic                hs_run_nxt;
   logic                int_run_nxt;
   logic [31:0]         rd_nxt;
   logic                access;
   logic                wr_en;

   // Reset release through two flip-flops.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_sync1_r <= 1'b0;
         rst_sync2_r <= 1'b0;
      end
      else
      begin
         rst_sync1_r <= 1'b1;
         rst_sync2_r <= rst_sync1_r;
      end
   end

   // Bus decode: one wait cycle, then acknowledge.
   assign access = (avs_read | avs_write) & wait_r;
   assign wr_en  = avs_write & ~wait_r;

   // Waitrequest drops for one cycle after the request is seen.
   // The flop itself drives the pin, so no gate sits on the output.
   always_ff @(posedge clk or negedge rst_sync2_r)
   begin
      if (!rst_sync2_r)
         wait_r <= 1'b1;
      else
         wait_r <= ~access;
   end

   assign avs_waitrequest = wait_r;

   // Setting flags written by software.
   always_ff @(posedge clk or negedge rst_sync2_r)
   begin
      if (!rst_sync2_r)
      begin
         main_source_select       <= ccs_pkg::MAIN_SEL_RST;
         sub_clock_select         <= ccs_pkg::SUB_SEL_RST;
         hs_osc_stop_by_proc_ctrl <= ccs_pkg::STOP_RST;
         main_osc_stop_flag       <= ccs_pkg::STOP_RST;
         int_osc_stop_flag        <= ccs_pkg::STOP_RST;
         osc_stab_time_select     <= ccs_pkg::STAB_SEL_RST;
      end
      else if (wr_en)
      begin
         case (avs_address)
            ccs_pkg::PROC_CLK_CTRL_OFS:
            begin
               hs_osc_stop_by_proc_ctrl <=
                  avs_writedata[ccs_pkg::HS_STOP_PROC_BIT];
               sub_clock_select <= avs_writedata[ccs_pkg::SUB_SEL_BIT];
            end
            ccs_pkg::MAIN_MODE_OFS:
               main_source_select <= avs_writedata[ccs_pkg::MAIN_SEL_BIT];
            ccs_pkg::MAIN_OSC_CTRL_OFS:
            begin
               main_osc_stop_flag <= avs_writedata[ccs_pkg::MAIN_STOP_BIT];
               osc_stab_time_select <=
                  avs_writedata[ccs_pkg::STAB_SEL_LSB +: 3];
            end
            ccs_pkg::INT_OSC_MODE_OFS:
               int_osc_stop_flag <= avs_writedata[ccs_pkg::INT_STOP_BIT];
            default:
            begin
            end
         endcase
      end
   end

   // Stabilization counter counts up until the oscillator reports stable.
   always_ff @(posedge clk or negedge rst_sync2_r)
   begin
      if (!rst_sync2_r)
         osc_stab_status_counter <= 16'h0000;
      else if (!hs_osc_stab_done && osc_stab_status_counter != 16'hFFFF)
         osc_stab_status_counter <= osc_stab_status_counter + 16'h0001;
   end

   // Requested source from the select flags.
   // Subsystem select alone chooses subsystem, whatever main select holds.
   assign req_src = sub_clock_select ? ccs_pkg::CCS_SRC_SUB :
                    main_source_select ? ccs_pkg::CCS_SRC_HS :
                    ccs_pkg::CCS_SRC_INT;

   ccs_switch u_switch
   (
      .clk     (clk),
      .rst_n   (rst_sync2_r),
      .req_src (req_src),
      .act_src (act_src),
      .gate_open (gate_open),
      .busy    (sw_busy)
   );

   assign sub_clock_status   = (act_src == ccs_pkg::CCS_SRC_SUB);
   assign main_source_status = (act_src != ccs_pkg::CCS_SRC_INT);

   // High-speed stop depends on active source.
   assign hs_run_nxt =
      (act_src == ccs_pkg::CCS_SRC_INT) ? ~main_osc_stop_flag :
      (act_src == ccs_pkg::CCS_SRC_SUB) ? ~hs_osc_stop_by_proc_ctrl :
      1'b1;

   // Internal stop honoured only when option permits.
   assign int_run_nxt = ~(int_osc_stop_flag & int_osc_sw_stoppable &
                          (act_src != ccs_pkg::CCS_SRC_INT));

   // Read mux with status bits.
   // Bit 1 reports active main source.
   always_comb
   begin
      rd_nxt = 32'h0000_0000;
      case (avs_address)
         ccs_pkg::PROC_CLK_CTRL_OFS:
         begin
            rd_nxt[ccs_pkg::HS_STOP_PROC_BIT] = hs_osc_stop_by_proc_ctrl;
            rd_nxt[ccs_pkg::SUB_STAT_BIT]     = sub_clock_status;
            rd_nxt[ccs_pkg::SUB_SEL_BIT]      = sub_clock_select;
         end
         ccs_pkg::MAIN_MODE_OFS:
         begin
            rd_nxt[ccs_pkg::MAIN_STAT_BIT] = main_source_status;
            rd_nxt[ccs_pkg::MAIN_SEL_BIT]  = main_source_select;
         end
         ccs_pkg::MAIN_OSC_CTRL_OFS:
         begin
            rd_nxt[ccs_pkg::MAIN_STOP_BIT] = main_osc_stop_flag;
            rd_nxt[ccs_pkg::STAB_SEL_LSB +: 3] = osc_stab_time_select;
            rd_nxt[31:16] = osc_stab_status_counter;
         end
         ccs_pkg::INT_OSC_MODE_OFS:
            rd_nxt[ccs_pkg::INT_STOP_BIT] = int_osc_stop_flag;
         default:
            rd_nxt = 32'h0000_0000;
      endcase
   end

   // Registered outputs.
   always_ff @(posedge clk or negedge rst_sync2_r)
   begin
      if (!rst_sync2_r)
      begin
         avs_readdata    <= 32'h0000_0000;
         hs_osc_run      <= 1'b0;
         int_osc_run     <= 1'b1;
         cpu_clk_src     <= 2'h0;
         cpu_clk_gate    <= 1'b0;
         stab_time_apply <= ccs_pkg::STAB_SEL_RST;
      end
      else
      begin
         avs_readdata <= access ? rd_nxt : avs_readdata;
         hs_osc_run   <= hs_run_nxt;
         int_osc_run  <= int_run_nxt;
         cpu_clk_src  <= act_src;
         cpu_clk_gate <= gate_open;
         // Stabilization select latched on stop exit from high-speed.
         if (stop_exit_by_irq && act_src == ccs_pkg::CCS_SRC_HS)
            stab_time_apply <= osc_stab_time_select;
      end
   end

   // High-speed oscillator keeps running on high-speed clock.
   a_hs_keeps_run: assert property (@(posedge clk)
      disable iff (!rst_sync2_r)
      (act_src == ccs_pkg::CCS_SRC_HS) ##1 (act_src == ccs_pkg::CCS_SRC_HS)
      |-> hs_osc_run)
      else $error("High-speed oscillator stopped on own clock.");

   // Processor stop halts oscillator on subsystem clock.
   a_proc_stop_sub: assert property (@(posedge clk)
      disable iff (!rst_sync2_r)
      (act_src == ccs_pkg::CCS_SRC_SUB && hs_osc_stop_by_proc_ctrl)
      |=> !hs_osc_run)
      else $error("Processor stop flag ignored on subsystem clock.");

   // Main stop flag ignored on subsystem clock.
   a_main_stop_sub: assert property (@(posedge clk)
      disable iff (!rst_sync2_r)
      (act_src == ccs_pkg::CCS_SRC_SUB && !hs_osc_stop_by_proc_ctrl)
      |=> hs_osc_run)
      else $error("Main stop flag acted on subsystem clock.");

   // Only main stop flag acts on internal clock.
   // The sampled reset copy skips the release edge, where outputs still reset.
   a_main_stop_int: assert property (@(posedge clk)
      disable iff (!rst_sync2_r)
      (rst_sync2_r && act_src == ccs_pkg::CCS_SRC_INT)
      |=> (hs_osc_run == !$past(main_osc_stop_flag)))
      else $error("Wrong high-speed control on internal clock.");

   // Internal oscillator runs unless option permits stop.
   a_int_no_stop: assert property (@(posedge clk)
      disable iff (!rst_sync2_r)
      !int_osc_sw_stoppable |=> int_osc_run)
      else $error("Internal oscillator stopped without permission.");

   // Internal stop on subsystem clock when permitted.
   a_int_stop_sub: assert property (@(posedge clk)
      disable iff (!rst_sync2_r)
      (act_src == ccs_pkg::CCS_SRC_SUB && int_osc_stop_flag &&
       int_osc_sw_stoppable) |=> !int_osc_run)
      else $error("Internal stop ignored on subsystem clock.");

   // Internal oscillator never stops while it clocks the CPU.
   a_int_own_run: assert property (@(posedge clk)
      disable iff (!rst_sync2_r)
      (act_src == ccs_pkg::CCS_SRC_INT) |=> int_osc_run)
      else $error("Internal oscillator stopped on own clock.");

   a_src_report: assert property (@(posedge clk)
      disable iff (!rst_sync2_r)
      cpu_clk_src == ccs_pkg::CCS_SRC_SUB |-> $past(sub_clock_status))
      else $error("Subsystem status mismatch.");

   // Applied time held unless stop exit on high-speed.
   a_stab_hold: assert property (@(posedge clk)
      disable iff (!rst_sync2_r)
      !(stop_exit_by_irq && act_src == ccs_pkg::CCS_SRC_HS)
      |=> $stable(stab_time_apply))
      else $error("Stabilization time changed outside stop exit.");

   // Stop exit on high-speed takes the selected time.
   a_stab_take: assert property (@(posedge clk)
      disable iff (!rst_sync2_r)
      (stop_exit_by_irq && act_src == ccs_pkg::CCS_SRC_HS)
      |=> (stab_time_apply == $past(osc_stab_time_select)))
      else $error("Stabilization time not taken on stop exit.");

   // CPU gate stays shut while the sequencer is busy.
   a_gate_busy: assert property (@(posedge clk)
      disable iff (!rst_sync2_r)
      sw_busy |=> !cpu_clk_gate)
      else $error("CPU clock gate open during changeover.");

   // Reported source only changes with the CPU gate shut.
   a_gate_src: assert property (@(posedge clk)
      disable iff (!rst_sync2_r)
      (cpu_clk_src != $past(cpu_clk_src)) |-> !cpu_clk_gate)
      else $error("CPU clock source changed with gate open.");

   // Waitrequest is low for one cycle per transfer.
   a_wait_single: assert property (@(posedge clk)
      disable iff (!rst_sync2_r)
      !avs_waitrequest |=> avs_waitrequest)
      else $error("Waitrequest low for more than one cycle.");

endmodule

`default_nettype wire

// File: rtl/ccs_pkg.sv
// Package of register map, field positions and timing counts for the selector.
package ccs_pkg;

   // Register word offsets (byte addresses, one 32-bit word each).
   localparam logic [3:0] PROC_CLK_CTRL_OFS = 4'h0;
   localparam logic [3:0] MAIN_MODE_OFS     = 4'h4;
   localparam logic [3:0] MAIN_OSC_CTRL_OFS = 4'h8;
   localparam logic [3:0] INT_OSC_MODE_OFS  = 4'hC;

   // Field positions.
   localparam int HS_STOP_PROC_BIT = 7;
   localparam int SUB_STAT_BIT     = 5;
   localparam int SUB_SEL_BIT      = 4;
   localparam int MAIN_STAT_BIT    = 1;
   localparam int MAIN_SEL_BIT     = 0;
   localparam int MAIN_STOP_BIT    = 7;
   localparam int INT_STOP_BIT     = 0;
   localparam int STAB_SEL_LSB     = 0;

   // Reset values of the setting flags.
   localparam logic MAIN_SEL_RST = 1'b0;
   localparam logic SUB_SEL_RST  = 1'b0;
   localparam logic STOP_RST     = 1'b0;
   localparam logic [2:0] STAB_SEL_RST = 3'h5;

   // Changeover timing, counted in cycles of clk, whichever source is being left.
   localparam int SWITCH_CLOCKS    = 2;
   localparam logic [1:0] SWITCH_CNT = 2'(SWITCH_CLOCKS - 1);

   // Active CPU clock source.
   typedef enum logic [1:0]
   {
      CCS_SRC_INT,
      CCS_SRC_HS,
      CCS_SRC_SUB
   } ccs_src_e;

endpackage

// File: rtl/ccs_switch.sv
// Glitch-free changeover sequencer for the CPU clock source.
`timescale 1ns/100ps
`default_nettype none

module ccs_switch
(
   // Clock and reset.
   input  wire logic            clk,
   input  wire logic            rst_n,
   // Requested and active source.
   input  wire ccs_pkg::ccs_src_e req_src,
   output var ccs_pkg::ccs_src_e  act_src,
   output logic                 gate_open,
   output logic                 busy
);

   typedef enum logic [1:0]
   {
      CCS_SW_RUN,
      CCS_SW_GATE,
      CCS_SW_ENABLE
   } ccs_sw_e;

   ccs_sw_e                cur_r;
   ccs_pkg::ccs_src_e      src_r;
   logic [1:0]             cnt_r;

   // Sequencer: close the old gate low, wait, then open on the new source.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cur_r <= CCS_SW_RUN;
         src_r <= ccs_pkg::CCS_SRC_INT;
         cnt_r <= 2'h0;
      end
      else
      begin
         case (cur_r)
            CCS_SW_RUN:
            begin
               if (req_src != src_r)
               begin
                  cur_r <= CCS_SW_GATE;
                  // Two-clock hold before the new source.
                  cnt_r <= ccs_pkg::SWITCH_CNT;
               end
            end
            CCS_SW_GATE:
            begin
               if (cnt_r == 2'h0)
               begin
                  cur_r <= CCS_SW_ENABLE;
                  src_r <= req_src;
               end
               else
               begin
                  cnt_r <= cnt_r - 2'h1;
               end
            end
            CCS_SW_ENABLE:
            begin
               cur_r <= CCS_SW_RUN;
            end
            default:
            begin
               cur_r <= CCS_SW_RUN;
            end
         endcase
      end
   end

   // Gate is open only while running steadily on one source.
   assign act_src   = src_r;
   assign gate_open = (cur_r == CCS_SW_RUN);
   assign busy      = (cur_r != CCS_SW_RUN);

   a_switch_bound: assert property (@(posedge clk)
      disable iff (!rst_n)
      (cur_r == CCS_SW_RUN && req_src != src_r)
      |-> ##3 (cur_r == CCS_SW_ENABLE))
      else $error("Changeover did not complete in bound.");

   a_gate_closed: assert property (@(posedge clk)
      disable iff (!rst_n)
      (src_r != $past(src_r)) |-> !gate_open)
      else $error("Source changed while gate open.");

endmodule

`default_nettype wire

// File: tb/ccs_osc_model.sv
// Behavioural oscillators that report when they have stabilized.
`timescale 1ns/100ps
`default_nettype none

module ccs_osc_model
#(
   parameter int STAB_CYCLES = 12
)
(
   // Clock and reset.
   input  wire logic clk,
   input  wire logic rst_n,
   // Oscillator control and status.
   input  wire logic hs_osc_run,
   output logic      hs_osc_stab_done,
   output logic      sub_osc_stab_done
);
   int cnt_r;
   int sub_cnt_r;

   // stabilization wait elapses
   // Stopping the oscillator restarts the wait, as a real crystal would.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_r            <= 0;
         hs_osc_stab_done <= 1'b0;
      end
      else if (!hs_osc_run)
      begin
         cnt_r            <= 0;
         hs_osc_stab_done <= 1'b0;
      end
      else
      begin
         if (cnt_r < STAB_CYCLES)
         begin
            cnt_r <= cnt_r + 1;
         end
         hs_osc_stab_done <= (cnt_r >= STAB_CYCLES - 1);
      end
   end

   // subsystem oscillator settles once after reset and then runs on.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         sub_cnt_r <= 0;
      else if (sub_cnt_r < STAB_CYCLES)
         sub_cnt_r <= sub_cnt_r + 1;
   end

   assign sub_osc_stab_done = (sub_cnt_r >= STAB_CYCLES);
endmodule

`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the CPU clock source selector.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
   logic        clk;
   logic        rst_n;
   logic [3:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        int_osc_sw_stoppable;
   logic        stop_exit_by_irq;
   logic        hs_osc_stab_done;
   logic        sub_osc_stab_done;
   logic        hs_osc_run;
   logic        int_osc_run;
   logic [1:0]  cpu_clk_src;
   logic        cpu_clk_gate;
   logic [2:0]  stab_time_apply;
   logic [31:0] q;
   int          bad_count;
   int          total_checks;

   // Device and oscillator model.
   ccs_top dut
   (
      .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .int_osc_sw_stoppable(int_osc_sw_stoppable),
      .stop_exit_by_irq(stop_exit_by_irq),
      .hs_osc_stab_done(hs_osc_stab_done), .hs_osc_run(hs_osc_run),
      .int_osc_run(int_osc_run), .cpu_clk_src(cpu_clk_src),
      .cpu_clk_gate(cpu_clk_gate), .stab_time_apply(stab_time_apply)
   );
   ccs_osc_model osc
   (
      .clk(clk), .rst_n(rst_n), .hs_osc_run(hs_osc_run),
      .hs_osc_stab_done(hs_osc_stab_done),
      .sub_osc_stab_done(sub_osc_stab_done)
   );

   //--------------------------------------------------------------
   // Helper tasks
   //--------------------------------------------------------------
   // Ends the run with the verdict.
   task automatic tally_and_finish();
      if (bad_count == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Counts one comparison and reports a mismatch.
   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         $display("ERROR %s expected %h seen %h", n, e, g);
         bad_count++;
      end
   endtask

   // Reports a wait that ran out and closes the run.
   task automatic give_up(input string n);
      $display("ERROR %s expected 1 seen 0", n);
      bad_count++;
      tally_and_finish();
   endtask

   // One Avalon transfer, held until waitrequest is sampled low.
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      avs_address   <= a;
      avs_write     <= wr;
      avs_read      <= !wr;
      avs_writedata <= d;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 20);
      q = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 20)
         give_up("bus_answer");
   endtask

   // Waits for a changeover and checks the gate around it.
   task automatic wait_src(input logic [1:0] s);
      int n;
      n = 0;
      while (cpu_clk_src !== s && n < 6)
      begin
         @(posedge clk);
         n++;
      end
      if (cpu_clk_src !== s)
         give_up("cpu_clk_src");
      chk("gate_at_change", 32'h0, 32'(cpu_clk_gate));
      repeat (4) @(posedge clk);
      chk("gate_reopen", 32'h1, 32'(cpu_clk_gate));
   endtask

   // Waits for the high-speed oscillator to settle.
   task automatic wait_stab();
      int n;
      n = 0;
      while (hs_osc_stab_done !== 1'b1 && n < 40)
      begin
         @(posedge clk);
         n++;
      end
      if (hs_osc_stab_done !== 1'b1)
         give_up("hs_osc_stab_done");
   endtask

   //--------------------------------------------------------------
   // Scenarios
   //--------------------------------------------------------------
   // Reset state, unmapped address and the internal clock mode.
   task automatic t_internal();
      bus(1'b0, 4'h4, 32'h0);
      chk("mode_reset", 32'h0, q & 32'h3);
      bus(1'b0, 4'h8, 32'h0);
      chk("stab_reset", 32'h5, q & 32'h7);
      chk("stab_count_run", 32'h1, 32'(q[31:16] != 16'h0000));
      bus(1'b1, 4'h2, 32'hFFFFFFFF);
      bus(1'b0, 4'h2, 32'h0);
      chk("unmapped", 32'h0, q);
      bus(1'b1, 4'h0, 32'h80);
      repeat (3) @(posedge clk);
      chk("hs_run_proc_stop", 32'h1, 32'(hs_osc_run));
      bus(1'b1, 4'h0, 32'h0);
      bus(1'b1, 4'h8, 32'h85);
      repeat (3) @(posedge clk);
      chk("hs_run_main_stop", 32'h0, 32'(hs_osc_run));
      bus(1'b1, 4'h8, 32'h05);
   endtask

   // Move to the high-speed clock and try the ignored stop flags.
   task automatic t_high_speed();
      wait_stab();
      bus(1'b1, 4'h4, 32'h1);
      wait_src(2'h1);
      bus(1'b0, 4'h4, 32'h0);
      chk("mode_hs", 32'h3, q & 32'h3);
      bus(1'b1, 4'h0, 32'h80);
      bus(1'b1, 4'h8, 32'h83);
      repeat (3) @(posedge clk);
      chk("hs_run_ignored", 32'h1, 32'(hs_osc_run));
      bus(1'b1, 4'h0, 32'h0);
      bus(1'b1, 4'h8, 32'h03);
      bus(1'b1, 4'hC, 32'h1);
      repeat (3) @(posedge clk);
      chk("int_run_locked", 32'h1, 32'(int_osc_run));
      bus(1'b1, 4'hC, 32'h0);
   endtask

   // Subsystem clock and its own stop rules.
   task automatic t_subsystem();
      // subsystem oscillator confirmed settled before select
      if (sub_osc_stab_done !== 1'b1)
         give_up("sub_osc_stab_done");
      bus(1'b1, 4'h0, 32'h10);
      wait_src(2'h2);
      bus(1'b0, 4'h0, 32'h0);
      chk("sub_status", 32'h30, q & 32'h30);
      bus(1'b0, 4'h4, 32'h0);
      chk("mode_sub", 32'h3, q & 32'h3);
      // main select stays set for the whole subsystem stay
      bus(1'b1, 4'h8, 32'h83);
      repeat (3) @(posedge clk);
      chk("hs_run_main_stop", 32'h1, 32'(hs_osc_run));
      bus(1'b1, 4'h0, 32'h90);
      repeat (3) @(posedge clk);
      chk("hs_run_proc_stop", 32'h0, 32'(hs_osc_run));
      int_osc_sw_stoppable <= 1'b1;
      bus(1'b1, 4'hC, 32'h1);
      repeat (3) @(posedge clk);
      chk("int_run_stop", 32'h0, 32'(int_osc_run));
      bus(1'b1, 4'hC, 32'h0);
      bus(1'b1, 4'h8, 32'h03);
      bus(1'b1, 4'h0, 32'h10);
      wait_stab();
      bus(1'b1, 4'h0, 32'h0);
      wait_src(2'h1);
      bus(1'b0, 4'h0, 32'h0);
      chk("sub_status_off", 32'h0, q & 32'h30);
   endtask

   // Stabilization time select applies only on exit from high-speed.
   task automatic t_stab_select();
      @(posedge clk);
      stop_exit_by_irq <= 1'b1;
      @(posedge clk);
      stop_exit_by_irq <= 1'b0;
      repeat (3) @(posedge clk);
      chk("stab_apply_hs", 32'h3, 32'(stab_time_apply));
      bus(1'b1, 4'h4, 32'h0);
      wait_src(2'h0);
      bus(1'b1, 4'h8, 32'h06);
      stop_exit_by_irq <= 1'b1;
      @(posedge clk);
      stop_exit_by_irq <= 1'b0;
      repeat (3) @(posedge clk);
      chk("stab_apply_int", 32'h3, 32'(stab_time_apply));
   endtask

   //--------------------------------------------------------------
   // Clock, reset and main sequence
   //--------------------------------------------------------------
   // Free-running 10 MHz clock.
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Reset, then every scenario in turn.
   initial
   begin
      bad_count            = 0;
      total_checks         = 0;
      rst_n                = 1'b0;
      avs_address          = 4'h0;
      avs_read             = 1'b0;
      avs_write            = 1'b0;
      avs_writedata        = 32'h0;
      int_osc_sw_stoppable = 1'b0;
      stop_exit_by_irq     = 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_internal();
      t_high_speed();
      t_subsystem();
      t_stab_select();
      tally_and_finish();
   end
endmodule

`default_nettype wire
